// *** core/gtm_cfg.svh ***
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH
`define GTM_OFS_PIN8      8'he8
`define GTM_OFS_PIN9      8'he9
`define GTM_OFS_PIN10     8'hea
`define GTM_OFS_PIN11     8'heb
`define GTM_OFS_SPUR      8'hf7
`define GTM_RST_MAP       8'h00
`define GTM_RST_SPUR      8'h00
`define GTM_DIR_BIT       7
`define GTM_RECFG_MS      200
`define GTM_CLK_MHZ       250
`define GTM_RECFG_CYC     (`GTM_RECFG_MS * 1000 * `GTM_CLK_MHZ)
`endif

// *** core/gtm_gpio_map.sv ***
`timescale 1ns/10ps
`include "gtm_cfg.svh"
module gtm_gpio_map #(
   parameter int unsigned RECFG_CYCLES = `GTM_RECFG_CYC
) (
   input  wire logic             clk_sys,      // 250 MHz system clock
   input  wire logic             resetn,       // Async reset, active low
   input  wire gtm_pkg::gtm_req_t req,         // Register access strobes
   output logic [7:0]            rdata,        // Read data, registered
   output logic                  reconfig_busy, // Reconfiguration running
   input  wire logic [127:0]     status_table, // Status bits from core
   output logic [127:0]          control_table, // Control bits to core
   input  wire logic [3:0]       pin_in,       // Pins 8..11 sampled level
   output logic [3:0]            pin_out,      // Pins 8..11 drive value
   output logic [3:0]            pin_oe        // Pins 8..11 drive enable
);
   // Register state, timer and pin synchroniser
   gtm_pkg::gtm_map_t    map_r [4];
   logic [7:0]           spur_r;
   logic [3:0]           pin_s1_r;
   logic [3:0]           pin_s2_r;
   logic [31:0]          cnt_r;
   gtm_pkg::gtm_state_t  state_r;
   logic [3:0]           used_r;

   // Pin address decode, shared by read and write paths
   function automatic logic [2:0] pin_sel(input logic [7:0] a);
      unique case (a)
         `GTM_OFS_PIN8:  pin_sel = 3'h4;
         `GTM_OFS_PIN9:  pin_sel = 3'h5;
         `GTM_OFS_PIN10: pin_sel = 3'h6;
         `GTM_OFS_PIN11: pin_sel = 3'h7;
         default:        pin_sel = 3'h0;
      endcase
   endfunction : pin_sel

   // A write that really changes the setting; a rewrite costs nothing
   wire logic spur_change = req.wr && req.addr == `GTM_OFS_SPUR
                            && req.wdata != spur_r;

   // Map registers; access during reconfiguration is the host's fault
   generate
      for (genvar i = 0; i < 4; i++) begin : g_pin
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               map_r[i]  <= `GTM_RST_MAP;
               used_r[i] <= 1'b0;
            end else if (req.wr && pin_sel(req.addr) == 3'(4 + i)) begin
               map_r[i]  <= req.wdata;
               used_r[i] <= 1'b1;
            end
         end
         // Status pin drives the indexed status bit
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               pin_out[i] <= 1'b0;
               pin_oe[i]  <= 1'b0;
            end else begin
               pin_out[i] <= status_table[map_r[i].map_index];
               pin_oe[i]  <= used_r[i] && map_r[i].dir_status;
            end
         end
      end
   endgenerate

   // Two-flop synchroniser for pin levels
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // Control table; later pins win if two map the same bit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         control_table <= 128'h0;
      end else begin
         for (int j = 0; j < 4; j++) begin
            if (used_r[j] && !map_r[j].dir_status)
               control_table[map_r[j].map_index] <= pin_s2_r[j];
         end
      end
   end

   // Spur setting register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         spur_r <= `GTM_RST_SPUR;
      else if (req.wr && req.addr == `GTM_OFS_SPUR)
         spur_r <= req.wdata;
   end

   // Reconfiguration timer; a rewrite of an unchanged value starts nothing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r       <= gtm_pkg::GTM_IDLE;
         cnt_r         <= 32'h0;
         reconfig_busy <= 1'b0;
      end else begin
         unique case (state_r)
            gtm_pkg::GTM_IDLE: begin
               if (spur_change) begin
                  state_r       <= gtm_pkg::GTM_RECFG;
                  cnt_r         <= 32'(RECFG_CYCLES - 1);
                  reconfig_busy <= 1'b1;
               end
            end
            gtm_pkg::GTM_RECFG: begin
               if (cnt_r == 32'h0) begin
                  state_r       <= gtm_pkg::GTM_IDLE;
                  reconfig_busy <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            // Illegal one-hot codes fall back to idle
            default: state_r <= gtm_pkg::GTM_IDLE;
         endcase
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         rdata <= 8'h00;
      else if (req.rd) begin
         if (pin_sel(req.addr) != 3'h0)
            rdata <= map_r[2'(pin_sel(req.addr) - 3'h4)];
         else if (req.addr == `GTM_OFS_SPUR)
            rdata <= spur_r;
         else
            rdata <= 8'h00;
      end
   end

   // Reconfiguration steps, shared by the timer checks below
   sequence s_spur_differs;
      req.wr && req.addr == `GTM_OFS_SPUR && req.wdata != spur_r;
   endsequence : s_spur_differs
   sequence s_spur_same;
      req.wr && req.addr == `GTM_OFS_SPUR && req.wdata == spur_r;
   endsequence : s_spur_same
   sequence s_busy_loaded;
      reconfig_busy && cnt_r == RECFG_CYCLES - 1;
   endsequence : s_busy_loaded
   sequence s_busy_last;
      reconfig_busy && cnt_r == 32'h0;
   endsequence : s_busy_last

   // Timer: starts on a change only, runs its full length, then drops
   a_recfg_starts: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      s_spur_differs ##0 !reconfig_busy |=> s_busy_loaded)
      else $error("reconfiguration did not start");
   a_busy_counts: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      reconfig_busy && cnt_r != 32'h0 |=>
      reconfig_busy && cnt_r == $past(cnt_r) - 32'h1)
      else $error("reconfiguration cut short");
   a_busy_ends: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      s_busy_last |=> !reconfig_busy)
      else $error("reconfiguration overran");
   a_count_bound: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      reconfig_busy |-> cnt_r < RECFG_CYCLES)
      else $error("reconfiguration count out of range");
   a_same_quiet: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      s_spur_same ##0 !reconfig_busy |=> !reconfig_busy)
      else $error("unchanged value started reconfiguration");

   // Spur register: stored on write, returned on read
   a_spur_store: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      req.wr && req.addr == `GTM_OFS_SPUR |=> spur_r == $past(req.wdata))
      else $error("spur value not stored");
   a_spur_readback: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      req.rd && req.addr == `GTM_OFS_SPUR |=> rdata == $past(spur_r))
      else $error("spur value not read back");

   // Pins: status pins drive, control pins listen, unused pins stay off
   a_status_drive: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      used_r[0] && map_r[0].dir_status && $stable(map_r[0]) |=>
      pin_oe[0] && pin_out[0] == $past(status_table[map_r[0].map_index]))
      else $error("status pin not driven");
   a_status_enable: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      used_r[3] && map_r[3].dir_status |=>
      pin_oe[3] && pin_out[3] == $past(status_table[map_r[3].map_index]))
      else $error("status pin not enabled");
   a_control_idle: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      !map_r[1].dir_status |=> !pin_oe[1])
      else $error("control pin driven");
   a_unused_quiet: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      !used_r[2] |=> !pin_oe[2])
      else $error("unused pin driven");
   a_control_capture: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      used_r[2] && !map_r[2].dir_status && !(used_r[3] &&
      !map_r[3].dir_status && map_r[3].map_index == map_r[2].map_index) |=>
      control_table[$past(map_r[2].map_index)] == $past(pin_s2_r[2]))
      else $error("control bit not captured");

   // Map registers: stored on write, returned on read
   a_map_store: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      req.wr && req.addr == `GTM_OFS_PIN11 |=> map_r[3] == $past(req.wdata))
      else $error("pin map not stored");
   a_map_readback: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      req.rd && req.addr == `GTM_OFS_PIN8 |=> rdata == $past(map_r[0]))
      else $error("pin map not read back");
endmodule : gtm_gpio_map

// *** core/gtm_pkg.sv ***
package gtm_pkg;
   // One pin map register split into its fields
   typedef struct packed {
      logic       dir_status;   // 1 = status output, 0 = control input
      logic [6:0] map_index;    // Bit address into a 128-bit table
   } gtm_map_t;
   // Register access strobe group
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gtm_req_t;
   typedef enum logic [1:0] {
      GTM_IDLE  = 2'b01,
      GTM_RECFG = 2'b10
   } gtm_state_t;
endpackage : gtm_pkg

// *** sim/gtm_board.sv ***
`timescale 1ns/10ps
module gtm_board (
   pin_out, // Device drive value
   pin_oe,  // Device drive enable
   level,   // Board level on pins
   pin_in   // Level seen by device
);
   input  wire logic [3:0] pin_out;
   input  wire logic [3:0] pin_oe;
   input  wire logic [3:0] level;
   output logic      [3:0] pin_in;
   // Device wins where it drives, board elsewhere
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule : gtm_board

// *** sim/gtm_gpio_map_tb.sv ***
`timescale 1ns/10ps
module gtm_gpio_map_tb;
   logic              clk_sys = 1'b0;
   logic              resetn = 1'b0;
   gtm_pkg::gtm_req_t req = '0;
   logic [127:0]      stat = '0;
   logic [3:0]        level = 4'h0;
   logic [7:0]        rdata;
   logic              busy;
   logic [127:0]      ctrl;
   logic [3:0]        p_in, p_out, p_oe;
   int                failures = 0;
   int                check_count = 0;
   // Free-running 250 MHz clock
   always #2 clk_sys = ~clk_sys;
   gtm_gpio_map #(.RECFG_CYCLES(20)) u_dut (.clk_sys(clk_sys),
      .resetn(resetn), .req(req), .rdata(rdata), .reconfig_busy(busy),
      .status_table(stat), .control_table(ctrl), .pin_in(p_in),
      .pin_out(p_out), .pin_oe(p_oe));
   gtm_board u_board (.pin_out(p_out), .pin_oe(p_oe), .level(level),
      .pin_in(p_in));
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   // One access; read data is settled when this returns
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
      @(negedge clk_sys);
      req <= '{wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge clk_sys);
      req <= '0;
   endtask : acc
   task automatic t_reset();
      logic [7:0] regs [6] = '{8'he8, 8'he9, 8'hea, 8'heb, 8'hf7, 8'h10};
      foreach (regs[i]) begin
         acc(1'b0, regs[i], 8'h00);
         check("reset value", rdata, 8'h00);
      end
      check("idle oe", 8'(p_oe), 8'h00);
      check("idle control", 8'(|ctrl), 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_status();
      stat[5] = 1'b1;
      stat[127] = 1'b1;
      acc(1'b1, 8'he8, 8'h85);
      acc(1'b1, 8'he9, 8'hff);
      repeat (3) @(negedge clk_sys);
      check("oe", 8'(p_oe), 8'h03);
      check("out", 8'(p_out), 8'h03);
      stat[127] = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("out", 8'(p_out), 8'h01);
      acc(1'b0, 8'he8, 8'h00);
      check("map", rdata, 8'h85);
      $display("status test done");
   endtask : t_status
   task automatic t_control();
      level = 4'h4;
      acc(1'b1, 8'hea, 8'h7f);
      repeat (6) @(negedge clk_sys);
      check("ctl", 8'(ctrl[127]), 8'h01);
      check("oe", 8'(p_oe), 8'h03);
      level = 4'h0;
      repeat (6) @(negedge clk_sys);
      check("ctl", 8'(ctrl[127]), 8'h00);
      $display("control test done");
   endtask : t_control
   // Host stays silent while busy, bounded wait
   task automatic t_spur();
      int n = 0;
      acc(1'b1, 8'hf7, 8'h5a);
      while (busy === 1'b1 && n < 100) begin
         n++;
         @(negedge clk_sys);
      end
      check("busy len", 8'(n), 8'h14);
      acc(1'b1, 8'hf7, 8'h5a);
      check("busy same", 8'(busy), 8'h00);
      acc(1'b0, 8'hf7, 8'h00);
      check("spur", rdata, 8'h5a);
      $display("spur test done");
   endtask : t_spur
   // Pin 11 as status output, then as control input
   task automatic t_pin11();
      acc(1'b1, 8'heb, 8'h85);
      repeat (3) @(negedge clk_sys);
      check("oe", 8'(p_oe), 8'h0b);
      check("out", 8'(p_out), 8'h09);
      acc(1'b0, 8'heb, 8'h00);
      check("map", rdata, 8'h85);
      level = 4'h8;
      acc(1'b1, 8'heb, 8'h00);
      repeat (6) @(negedge clk_sys);
      check("oe", 8'(p_oe), 8'h03);
      check("ctl", 8'(ctrl[0]), 8'h01);
      level = 4'h0;
      repeat (6) @(negedge clk_sys);
      check("ctl", 8'(ctrl[0]), 8'h00);
      $display("pin 11 test done");
   endtask : t_pin11
   // Reset in mid-run returns pin 8 map, spur, pin enables and control table to default
   task automatic t_rerun();
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("oe in reset", 8'(p_oe), 8'h00);
      resetn = 1'b1;
      acc(1'b0, 8'he8, 8'h00);
      check("map after reset", rdata, 8'h00);
      acc(1'b0, 8'hf7, 8'h00);
      check("spur after reset", rdata, 8'h00);
      check("ctl after reset", 8'(|ctrl), 8'h00);
      $display("mid-run reset test done");
   endtask : t_rerun
   task automatic conclude();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (16) @(negedge clk_sys);
      resetn = 1'b1;
      t_reset();
      t_status();
      t_control();
      t_pin11();
      t_spur();
      t_rerun();
      conclude();
   end
   // Watchdog, well beyond the hundred-odd cycles needed
   initial begin
      #20000;
      failures++;
      conclude();
   end
endmodule : gtm_gpio_map_tb
